/* File: sim/ds3_rx_data_link_controller_tb_top.sv */
// Self-checking bench joining the framer end and controller end through the link.
`timescale 1ns/10ps
module ds3_rx_data_link_controller_tb_top;
  typedef struct {
    logic wr;
    logic [9:0] idx;
    logic [31:0] wd;
    logic [31:0] exp;
    logic err;
  } rdl_row_s;
  logic pclk;
  logic presetn;
  logic src_bit;
  logic src_stb;
  rdl_pkg::rdl_oh_e src_kind;
  logic [2:0] src_fframe;
  logic psel, penable, pwrite, pready, pslverr, irq, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] kinds[4];
  rdl_row_s rows[11];
  int err_count, compares, ones;
  rdl_link_if link_i (.pclk(pclk));
  rdl_framer_end i_rdl_framer_end (.pclk(pclk), .presetn(presetn), .src_bit(src_bit),
    .src_stb(src_stb), .src_kind(src_kind), .src_fframe(src_fframe), .link(link_i));
  rdl_ctrl_end i_rdl_ctrl_end (.pclk(pclk), .presetn(presetn), .link(link_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));
  rdl_link_checker i_rdl_link_checker (.pclk(pclk), .presetn(presetn), .src_bit(src_bit),
    .src_stb(src_stb), .src_kind(src_kind), .oh_bit(link_i.oh_bit), .oh_stb(link_i.oh_stb),
    .oh_kind(link_i.oh_kind), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  // ****
  // Shared tasks
  // ****
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    check({31'h0, pready}, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd_chk(input logic [9:0] idx, input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    check(rd & mask, exp);
  endtask
  task automatic send_bit(input rdl_pkg::rdl_oh_e k, input logic [2:0] ff, input logic b);
    src_kind <= k;
    src_fframe <= ff;
    src_bit <= b;
    src_stb <= 1'b1;
    @(posedge pclk);
  endtask
  task automatic idle();
    src_stb <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic send_alarm(input logic [5:0] c);
    for (int j = 0; j < 16; j++) begin
      send_bit(rdl_pkg::OH_ALARM, 3'h0, j < 8 || (j > 8 && j < 15 && c[j - 9]));
    end
  endtask
  // Octets go out LSB first; a zero follows every run of five consecutive ones when stuffing.
  task automatic send_oct(input logic [7:0] b, input logic stuff, input logic [2:0] ff);
    for (int j = 0; j < 8; j++) begin
      send_bit(rdl_pkg::OH_LINK, ff, b[j]);
      ones = (b[j] && stuff) ? ones + 1 : 0;
      if (ones == 5) begin
        send_bit(rdl_pkg::OH_LINK, ff, 1'b0);
        ones = 0;
      end
    end
  endtask
  task automatic send_msg(input logic [7:0] kind, input logic bad);
    logic [7:0] m[7];
    logic [15:0] c;
    m = '{8'h3e, 8'h01, 8'h03, kind, 8'hff, 8'h00, 8'h00};
    c = rdl_pkg::CRC_INIT;
    for (int i = 0; i < 40; i++) begin
      c = (c >> 1) ^ ((c[0] ^ m[i / 8][i % 8]) ? rdl_pkg::CRC_POLY_REV : 16'h0000);
    end
    c = ~c ^ {15'h0, bad};
    m[5] = c[7:0];
    m[6] = c[15:8];
    send_oct(rdl_pkg::FLAG_OCTET, 1'b0, 3'h5);
    for (int i = 0; i < 7; i++) send_oct(m[i], 1'b1, 3'h5);
    send_oct(rdl_pkg::FLAG_OCTET, 1'b0, 3'h5);
    idle();
  endtask
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    end_sim();
  end
  initial begin
    {presetn, src_bit, src_stb, src_fframe, psel, penable, pwrite, paddr, pwdata} = '0;
    src_kind = rdl_pkg::OH_OTHER;
    ones = 0;
    kinds = '{rdl_pkg::KIND_TEST, rdl_pkg::KIND_IDLE, rdl_pkg::KIND_CL, rdl_pkg::KIND_ITU};
    rows = '{'{0, 10'h016, 0, 0, 0}, '{0, 10'h017, 0, 0, 0}, '{0, 10'h018, 0, 0, 0},
      '{1, 10'h017, 32'h0a, 0, 0}, '{0, 10'h017, 0, 32'h0a, 0}, '{1, 10'h018, 32'h02, 0, 0},
      '{0, 10'h018, 0, 32'h02, 0}, '{1, 10'h016, 32'hff, 0, 0}, '{0, 10'h016, 0, 0, 0},
      '{0, 10'h040, 0, 0, 1}, '{1, 10'h040, 32'h5a, 0, 1}};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].idx, rows[i].wd);
      check({31'h0, er}, {31'h0, rows[i].err});
      if (!rows[i].wr) check(rd, rows[i].exp);
    end
    $display("test registers done");
    for (int i = 0; i < 7; i++) send_alarm(6'h15);
    idle();
    check({31'h0, irq}, 32'h0);
    rd_chk(10'h017, 32'hffffffff, 32'h0a);
    send_alarm(6'h15);
    idle();
    check({31'h0, irq}, 32'h1);
    rd_chk(10'h017, 32'hffffffff, 32'h1b);
    check({31'h0, irq}, 32'h0);
    rd_chk(10'h016, 32'hffffffff, 32'h2a);
    for (int i = 0; i < 4; i++) send_alarm(i < 2 ? 6'h15 : 6'h2a);
    idle();
    rd_chk(10'h017, 32'hffffffff, 32'h1a);
    send_alarm(6'h2a);
    idle();
    check({31'h0, irq}, 32'h1);
    rd_chk(10'h017, 32'hffffffff, 32'h0e);
    rd_chk(10'h017, 32'hffffffff, 32'h0a);
    $display("test alarm code done");
    send_oct(rdl_pkg::FLAG_OCTET, 1'b0, 3'h5);
    idle();
    rd_chk(10'h019, 32'h1, 32'h0);
    apb(1'b1, 10'h018, 32'h06);
    send_oct(rdl_pkg::FLAG_OCTET, 1'b0, 3'h4);
    idle();
    rd_chk(10'h019, 32'h1, 32'h0);
    send_oct(rdl_pkg::FLAG_OCTET, 1'b0, 3'h5);
    idle();
    rd_chk(10'h019, 32'h1, 32'h1);
    send_oct(8'h3c, 1'b1, 3'h5);
    idle();
    rd_chk(10'h019, 32'h1, 32'h0);
    $display("test flag hunt done");
    for (int i = 0; i < 5; i++) begin
      send_msg(kinds[i < 3 ? i : i - 1], i == 4);
      check({31'h0, irq}, {31'h0, i != 3});
      rd_chk(10'h018, 32'hff, (i == 3) ? 32'h06 : 32'h07);
      rd_chk(10'h019, 32'hff, 32'h0b | ((i < 3 ? i : i - 1) << 4)
        | (i == 4 ? 32'h04 : 32'h0));
      if (i < 4) rd_chk(10'h0de, 32'hff, {24'h0, kinds[i < 3 ? i : i - 1]});
      if (i < 4) rd_chk(10'h0df, 32'hff, 32'hff);
    end
    $display("test messages done");
    send_oct(rdl_pkg::FLAG_OCTET, 1'b0, 3'h5);
    for (int j = 0; j < 8; j++) send_bit(rdl_pkg::OH_LINK, 3'h5, 1'b1);
    idle();
    rd_chk(10'h019, 32'h40, 32'h40);
    $display("test abort done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    check(prdata, 32'h0);
    presetn <= 1'b1;
    rd_chk(10'h016, 32'hff, 32'h0);
    rd_chk(10'h017, 32'hff, 32'h0);
    rd_chk(10'h018, 32'hff, 32'h0);
    rd_chk(10'h019, 32'hff, 32'h0);
    $display("test reset done");
    end_sim();
  end
endmodule

/* File: sim/rdl_link_checker.sv */
// Assertions on the overhead link and register port of the receive data-link controller.
`timescale 1ns/10ps
module rdl_link_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Overhead link
  input wire logic src_bit,
  input wire logic src_stb,
  input wire rdl_pkg::rdl_oh_e src_kind,
  input wire logic oh_bit,
  input wire logic oh_stb,
  input wire rdl_pkg::rdl_oh_e oh_kind,
  // Register port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_ready_pulse;
    pready ##1 !pready;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> s_ready_pulse)
    else $error("access cycle did not answer exactly once");
  a_ready_needs_setup: assert property ($rose(pready) |-> $past(psel && !penable))
    else $error("ready raised without a setup cycle");
  a_err_reads_zero: assert property (pslverr |-> prdata == 32'h0000_0000)
    else $error("refused access returned nonzero data");
  a_rdata_holds: assert property (!(psel && !penable) |=> $stable(prdata) && $stable(pslverr))
    else $error("read data changed outside a setup edge");
  a_link_follows_src: assert property (src_stb |=> oh_stb && oh_bit == $past(src_bit)
    && oh_kind == $past(src_kind))
    else $error("link strobe did not carry the source bit");
  a_link_no_spurious: assert property (!src_stb |=> !oh_stb && $stable(oh_bit)
    && $stable(oh_kind))
    else $error("link moved without a source strobe");
  a_irq_rise_cause: assert property ($rose(irq) |-> $past(oh_stb)
    || $past(psel && penable && pwrite))
    else $error("interrupt rose without a bit or a write");
  a_irq_fall_cause: assert property ($fell(irq) |-> $past(psel && penable && pready))
    else $error("interrupt fell without a register access");
endmodule

/* File: verilog/rdl_ctrl_end.sv */
// Receive data-link controller: alarm code processor and message receiver.
//
// Notes on behaviour
// R1 - Drop held code when 3 of 10 differ.
// R2 - Drop sets flag, interrupts when enabled.
// R3 - Drop clears the code-held bit 4.
// R4 - Held code sits in bits 6:1.
// R5 - Accepted code interrupts; processor reads it.
// R6 - Message bits come from F-frame 5 DL.
// R7 - Payload stored in buffer 0xDE to 0x135.
// R8 - Stuffed zeros never reach stored bytes.
// R9 - Flag octet 0x7E opens and closes frames.
// R10 - Sender uses fixed header octet values.
// R11 - Check sequence is CRC-16, compared here.
// R12 - First info byte gives message type.
// R13 - Receiver idle until enable bit 2 set.
// R14 - Enabled receiver hunts flags continuously.
// R15 - Flag found sets flag-present bit 0.
// R16 - Non-flag octet clears flag-present bit; code clears it only in a frame, not while hunting after an abort.
// R17 - Seven ones after flag set abort bit.
// R18 - Status shows end, error, C/R, type.
// R19 - Accept code seen 8 of last 10.
// R20 - Alarm frame: eight ones, zeros around code.
// R21 - Zero after five ones is deleted.
// R22 - End interrupt only for a changed message.
// R23 - Interrupt while any enabled flag set.
//
// Chosen here: the APB slave port.
`timescale 1ns/10ps
module rdl_ctrl_end (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Overhead link from the framer
  rdl_link_if.dev link,
  // APB register port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt request
  output logic irq
);
  typedef struct packed {
    logic [15:0] fsr;
    logic [rdl_pkg::HIST_LEN-1:0][5:0] hist;
    logic [rdl_pkg::HIST_LEN-1:0] hv;
    logic held;
    logic [5:0] code;
    logic acc_en;
    logic acc_flag;
    logic drop_en;
    logic drop_flag;
    logic rx_on;
    logic msg_en;
    logic msg_flag;
    rdl_pkg::rdl_msg_e st;
    logic [7:0] win;
    logic [2:0] ones;
    logic [7:0] dbyte;
    logic [2:0] bcnt;
    logic [6:0] nbytes;
    logic [6:0] prev_len;
    logic [15:0] crc;
    logic differs;
    logic flag_pres;
    logic msg_complete;
    logic fcs_bad;
    logic cr;
    logic [1:0] kind;
    logic abort;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } rdl_ctrl_s;

  rdl_ctrl_s r_reg;
  rdl_ctrl_s r_next;
  logic [7:0] buf_mem [rdl_pkg::BUF_DEPTH];
  logic buf_we;
  logic [6:0] buf_wa;
  logic [7:0] buf_wd;
  logic [9:0] idx;
  logic [9:0] buf_ra;
  logic [15:0] fsr_new;
  logic [5:0] code_new;
  logic [rdl_pkg::HIST_LEN-1:0] same_v;
  logic [rdl_pkg::HIST_LEN-1:0] diff_v;
  logic [7:0] byte_new;
  logic [2:0] ones_new;
  logic [7:0] win_new;
  logic [6:0] slot;
  logic [7:0] rd8;

  function automatic logic [15:0] crc_byte(input logic [15:0] c_in, input logic [7:0] d);
    logic [15:0] c;
    c = c_in;
    for (int i = 0; i < 8; i++) begin
      if (c[0] ^ d[i]) begin
        c = (c >> 1) ^ rdl_pkg::CRC_POLY_REV;
      end else begin
        c = c >> 1;
      end
    end
    return c;
  endfunction

  function automatic logic [3:0] count_ones(input logic [rdl_pkg::HIST_LEN-1:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < rdl_pkg::HIST_LEN; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction

  function automatic logic [1:0] kind_of(input logic [7:0] b);
    case (b)
      rdl_pkg::KIND_IDLE: kind_of = 2'h1;
      rdl_pkg::KIND_CL: kind_of = 2'h2;
      rdl_pkg::KIND_ITU: kind_of = 2'h3;
      default: kind_of = 2'h0;
    endcase
  endfunction

  // ****************************************
  // Alarm code history compare
  // ****************************************
  assign fsr_new = {link.oh_bit, r_reg.fsr[15:1]};
  assign code_new = fsr_new[14:9];
  // R19 match counting
  generate
    for (genvar g = 0; g < rdl_pkg::HIST_LEN; g++) begin : g_hist
      if (g == 0) begin : g_new
        assign same_v[g] = 1'b1;
        assign diff_v[g] = (code_new != r_reg.code);
      end else begin : g_old
        assign same_v[g] = r_reg.hv[g-1] && (r_reg.hist[g-1] == code_new);
        assign diff_v[g] = r_reg.hv[g-1] && (r_reg.hist[g-1] != r_reg.code);
      end
    end
  endgenerate

  assign idx = paddr[11:2];
  assign buf_ra = idx - rdl_pkg::IDX_BUF_FIRST;
  assign win_new = {link.oh_bit, r_reg.win[7:1]};
  assign byte_new = {link.oh_bit, r_reg.dbyte[7:1]};
  assign slot = r_reg.nbytes - rdl_pkg::HDR_BYTES;

  always_comb begin
    r_next = r_reg;
    buf_we = 1'b0;
    buf_wa = slot;
    buf_wd = byte_new;
    rd8 = 8'h00;
    ones_new = 3'h0;
    // ****************************************
    // APB slave
    // ****************************************
    r_next.pready = psel && !penable;
    if (psel && !penable) begin
      r_next.pslverr = 1'b0;
      if (idx == rdl_pkg::IDX_CODE) begin
        // R4 code placement
        rd8 = {1'b0, r_reg.code, 1'b0};
      end else if (idx == rdl_pkg::IDX_CODE_IRQ) begin
        rd8 = {3'h0, r_reg.held, r_reg.drop_en, r_reg.drop_flag, r_reg.acc_en, r_reg.acc_flag};
      end else if (idx == rdl_pkg::IDX_MSG_CTRL) begin
        rd8 = {5'h00, r_reg.rx_on, r_reg.msg_en, r_reg.msg_flag};
      end else if (idx == rdl_pkg::IDX_MSG_STATE) begin
        // R18 status layout
        rd8 = {1'b0, r_reg.abort, r_reg.kind, r_reg.cr, r_reg.fcs_bad, r_reg.msg_complete,
               r_reg.flag_pres};
      end else if (idx >= rdl_pkg::IDX_BUF_FIRST && idx <= rdl_pkg::IDX_BUF_LAST) begin
        rd8 = buf_mem[buf_ra[6:0]];
      end else begin
        r_next.pslverr = 1'b1;
      end
      r_next.prdata = {24'h000000, rd8};
    end
    if (psel && penable && r_reg.pready && !r_reg.pslverr) begin
      if (pwrite && idx == rdl_pkg::IDX_CODE_IRQ) begin
        r_next.drop_en = pwdata[rdl_pkg::CI_DROP_EN];
        r_next.acc_en = pwdata[rdl_pkg::CI_ACC_EN];
      end else if (pwrite && idx == rdl_pkg::IDX_MSG_CTRL) begin
        r_next.rx_on = pwdata[rdl_pkg::MC_ON];
        r_next.msg_en = pwdata[rdl_pkg::MC_IRQ_EN];
      end else if (!pwrite && idx == rdl_pkg::IDX_CODE_IRQ) begin
        r_next.drop_flag = 1'b0;
        r_next.acc_flag = 1'b0;
      end else if (!pwrite && idx == rdl_pkg::IDX_MSG_CTRL) begin
        r_next.msg_flag = 1'b0;
      end
    end
    // ****************************************
    // Alarm code processor
    // ****************************************
    if (link.oh_stb && link.oh_kind == rdl_pkg::OH_ALARM) begin
      r_next.fsr = fsr_new;
      // R20 alarm framing
      if (fsr_new[7:0] == 8'hff && !fsr_new[8] && !fsr_new[15]) begin
        r_next.fsr = 16'h0000;
        r_next.hist = {r_reg.hist[rdl_pkg::HIST_LEN-2:0], code_new};
        r_next.hv = {r_reg.hv[rdl_pkg::HIST_LEN-2:0], 1'b1};
        if (!r_reg.held && count_ones(same_v) >= rdl_pkg::ACCEPT_COUNT) begin
          // R19 R5 accept
          r_next.held = 1'b1;
          r_next.code = code_new;
          r_next.acc_flag = 1'b1;
        end else if (r_reg.held && count_ones(diff_v) >= rdl_pkg::DROP_COUNT) begin
          // R1 R2 R3 drop
          r_next.held = 1'b0;
          r_next.drop_flag = 1'b1;
        end
      end
    end
    // ****************************************
    // Message receiver
    // ****************************************
    // R13 idle when off
    if (!r_reg.rx_on) begin
      r_next.st = rdl_pkg::ST_HUNT;
    end else if (link.oh_stb && link.oh_kind == rdl_pkg::OH_LINK &&
                 link.oh_fframe == rdl_pkg::FFRAME_DL) begin
      // R6 R14 bit intake and flag hunt
      r_next.win = win_new;
      if (link.oh_bit) begin
        ones_new = (r_reg.ones == rdl_pkg::ABORT_RUN) ? r_reg.ones : r_reg.ones + 3'h1;
      end
      r_next.ones = ones_new;
      if (win_new == rdl_pkg::FLAG_OCTET) begin
        // R9 R15 flag delimiter
        r_next.flag_pres = 1'b1;
        if (r_reg.st == rdl_pkg::ST_FRAME && r_reg.nbytes >= rdl_pkg::MIN_BYTES) begin
          // R11 R18 end of message
          r_next.msg_complete = 1'b1;
          r_next.fcs_bad = (r_reg.crc != rdl_pkg::CRC_RESIDUE);
          // R22 changed message only
          if (r_reg.differs || r_reg.nbytes != r_reg.prev_len) begin
            r_next.msg_flag = 1'b1;
          end
          r_next.prev_len = r_reg.nbytes;
        end
        r_next.st = rdl_pkg::ST_FRAME;
        r_next.bcnt = 3'h0;
        r_next.nbytes = 7'h00;
        r_next.crc = rdl_pkg::CRC_INIT;
        r_next.differs = 1'b0;
      end else if (r_reg.st == rdl_pkg::ST_FRAME) begin
        if (ones_new == rdl_pkg::ABORT_RUN) begin
          // R17 abort
          r_next.abort = 1'b1;
          r_next.st = rdl_pkg::ST_HUNT;
        // R8 R21 stuffed zero removal
        end else if (link.oh_bit || r_reg.ones != rdl_pkg::STUFF_RUN) begin
          r_next.dbyte = byte_new;
          r_next.bcnt = r_reg.bcnt + 3'h1;
          if (r_reg.bcnt == 3'h7) begin
            // R16 non-flag octet
            r_next.flag_pres = 1'b0;
            r_next.crc = crc_byte(r_reg.crc, byte_new);
            if (r_reg.nbytes != 7'h7f) begin
              r_next.nbytes = r_reg.nbytes + 7'h01;
            end
            if (r_reg.nbytes == 7'h00) begin
              r_next.msg_complete = 1'b0;
              r_next.abort = 1'b0;
              r_next.fcs_bad = 1'b0;
              r_next.cr = byte_new[1];
            end
            if (r_reg.nbytes == rdl_pkg::HDR_BYTES) begin
              // R12 type byte
              r_next.kind = kind_of(byte_new);
            end
            if (r_reg.nbytes >= rdl_pkg::HDR_BYTES &&
                slot < 7'(rdl_pkg::BUF_DEPTH)) begin
              // R7 buffer write
              buf_we = 1'b1;
              if (buf_mem[slot] != byte_new) begin
                r_next.differs = 1'b1;
              end
            end
          end
        end
      end
    end
    // R23 interrupt request
    r_next.irq = (r_next.acc_flag && r_next.acc_en) || (r_next.drop_flag && r_next.drop_en) ||
                 (r_next.msg_flag && r_next.msg_en);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
      r_reg.acc_en <= rdl_pkg::RST_ACC_EN;
      r_reg.drop_en <= rdl_pkg::RST_DROP_EN;
      r_reg.msg_en <= rdl_pkg::RST_MSG_EN;
      r_reg.rx_on <= rdl_pkg::RST_RX_ON;
    end else begin
      r_reg <= r_next;
    end
  end

  always_ff @(posedge pclk) begin
    if (buf_we) begin
      buf_mem[buf_wa] <= buf_wd;
    end
  end

  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign irq = r_reg.irq;
endmodule

/* File: verilog/rdl_framer_end.sv */
// Framer end of the overhead link: presents one overhead bit per strobe.
`timescale 1ns/10ps
module rdl_framer_end (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Overhead bits from the framer core
  input wire logic src_bit,
  input wire logic src_stb,
  input wire rdl_pkg::rdl_oh_e src_kind,
  input wire logic [2:0] src_fframe,
  // Link toward the controller
  rdl_link_if.frm link
);
  typedef struct packed {
    logic bit_v;
    logic stb;
    rdl_pkg::rdl_oh_e kind;
    logic [2:0] fframe;
  } rdl_frm_s;

  rdl_frm_s r_reg;
  rdl_frm_s r_next;

  always_comb begin
    r_next = r_reg;
    r_next.stb = src_stb;
    if (src_stb) begin
      r_next.bit_v = src_bit;
      r_next.kind = src_kind;
      r_next.fframe = src_fframe;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign link.oh_bit = r_reg.bit_v;
  assign link.oh_stb = r_reg.stb;
  assign link.oh_kind = r_reg.kind;
  assign link.oh_fframe = r_reg.fframe;
endmodule

/* File: verilog/rdl_link_if.sv */
// Overhead bit link from the receive framer to the data-link controller.
`timescale 1ns/10ps
interface rdl_link_if (
  input wire logic pclk
);
  logic oh_bit;
  logic oh_stb;
  rdl_pkg::rdl_oh_e oh_kind;
  logic [2:0] oh_fframe;
  modport dev (input oh_bit, input oh_stb, input oh_kind, input oh_fframe);
  modport frm (output oh_bit, output oh_stb, output oh_kind, output oh_fframe);
endinterface

/* File: verilog/rdl_pkg.sv */
// Shared constants and types for the receive data-link controller.
package rdl_pkg;
  // ****************************************
  // Register indexes (byte address is four times the index)
  // ****************************************
  localparam logic [9:0] IDX_CODE = 10'h016;
  localparam logic [9:0] IDX_CODE_IRQ = 10'h017;
  localparam logic [9:0] IDX_MSG_CTRL = 10'h018;
  localparam logic [9:0] IDX_MSG_STATE = 10'h019;
  localparam logic [9:0] IDX_BUF_FIRST = 10'h0de;
  localparam logic [9:0] IDX_BUF_LAST = 10'h135;
  localparam int BUF_DEPTH = 88;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int CI_ACC_FLAG = 0;
  localparam int CI_ACC_EN = 1;
  localparam int CI_DROP_FLAG = 2;
  localparam int CI_DROP_EN = 3;
  localparam int CI_HELD = 4;
  localparam int MC_FLAG = 0;
  localparam int MC_IRQ_EN = 1;
  localparam int MC_ON = 2;
  localparam int MS_FLAG = 0;
  localparam int MS_EOM = 1;
  localparam int MS_FCS = 2;
  localparam int MS_CR = 3;
  localparam int MS_KIND = 4;
  localparam int MS_ABORT = 6;
  // ****************************************
  // Reset values of the writable enables
  // ****************************************
  localparam logic RST_ACC_EN = 1'b0;
  localparam logic RST_DROP_EN = 1'b0;
  localparam logic RST_MSG_EN = 1'b0;
  localparam logic RST_RX_ON = 1'b0;
  // ****************************************
  // Alarm code and message framing figures
  // ****************************************
  localparam int HIST_LEN = 10;
  localparam logic [3:0] ACCEPT_COUNT = 4'h8;
  localparam logic [3:0] DROP_COUNT = 4'h3;
  localparam logic [7:0] FLAG_OCTET = 8'h7e;
  localparam logic [2:0] STUFF_RUN = 3'h5;
  localparam logic [2:0] ABORT_RUN = 3'h7;
  localparam logic [2:0] FFRAME_DL = 3'h5;
  localparam logic [6:0] HDR_BYTES = 7'h03;
  localparam logic [6:0] MIN_BYTES = 7'h05;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY_REV = 16'h8408;
  localparam logic [15:0] CRC_RESIDUE = 16'hf0b8;
  localparam logic [7:0] KIND_TEST = 8'h32;
  localparam logic [7:0] KIND_IDLE = 8'h34;
  localparam logic [7:0] KIND_CL = 8'h38;
  localparam logic [7:0] KIND_ITU = 8'h3f;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    OH_OTHER = 2'b00,
    OH_ALARM = 2'b01,
    OH_LINK = 2'b10
  } rdl_oh_e;
  typedef enum logic {
    ST_HUNT = 1'b0,
    ST_FRAME = 1'b1
  } rdl_msg_e;
endpackage
